/* logic/lin_regs.vh */
`ifndef LIN_STATUS_CONFIG_REGS_VH
`define LIN_STATUS_CONFIG_REGS_VH
// Register indices (byte address on the bus is index * 4)
`define IDX_STATUS 8'hC1
`define IDX_IRQ_EN 8'hC2
`define IDX_ERROR 8'hC3
`define IDX_BIT_TIMING 8'hC4
`define IDX_DIV_LOW 8'hC5
`define IDX_DIV_HIGH 8'hC6
`define IDX_RESP_LEN 8'hC7
`define IDX_FRAME_ID 8'hC8
`define IDX_CONTROL 8'hC0
`define IDX_DATA_PORT 8'hCA
`define IDX_EVENT 8'hD0
// Reset values
`define RST_BIT_TIMING 8'h20
`define RST_SPB 6'h20
`define RST_ZERO 8'h00
// Status bit positions
`define ST_ERR 3
`define ST_HDR 2
`define ST_TX 1
`define ST_RX 0
`define ST_BUSY 4
// Samples per bit limits
`define SPB_MIN 6'h08
`define SPB_MAX 6'h3F
// Length clamp
`define LEN_MAX 4'h8
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Special identifier base
`define SPECIAL_ID_HI 4'hF
`endif

/* logic/sample_tick_gen.v */
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Divider setting and enable
  input wire [DIV_W-1:0] divider,
  input wire run,
  // Sample enable pulse
  output reg tick_q
);
  reg [DIV_W-1:0] cnt_q;

  // One pulse every divider+1 clocks
  always @(posedge aclk)
  begin
    if (!aresetn || !run)
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (cnt_q >= divider)
    begin
      cnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* logic/id_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "lin_regs.vh"
module id_decode (
  // Identifier register contents and mode
  input wire [5:0] id_field,
  input wire legacy_protocol_sel,
  input wire [7:0] len_field,
  // Decoded results
  output wire [1:0] id_parity_bits,
  output wire [5:0] frame_id,
  output wire [2:0] special_id,
  output wire [3:0] tx_byte_count,
  output wire [3:0] rx_byte_count
);
  wire [1:0] legacy_length_code;
  wire [3:0] legacy_len;

  // Protected identifier parity
  assign id_parity_bits[0] = id_field[0] ^ id_field[1] ^ id_field[2] ^ id_field[4];
  assign id_parity_bits[1] = ~(id_field[1] ^ id_field[3] ^ id_field[4] ^ id_field[5]);
  // Identifier width depends on protocol version
  assign frame_id = legacy_protocol_sel ? {2'h0, id_field[3:0]} : id_field;
  assign special_id = (frame_id[5:2] == `SPECIAL_ID_HI) ? {1'b1, frame_id[1:0]} : 3'h0;
  // Legacy length code
  assign legacy_length_code = id_field[5:4];
  assign legacy_len = (legacy_length_code == 2'h3) ? 4'h8 :
                      (legacy_length_code == 2'h2) ? 4'h4 : 4'h2;
  // Byte counts, clamped to eight
  assign tx_byte_count = legacy_protocol_sel ? legacy_len :
                         (len_field[7:4] > `LEN_MAX) ? `LEN_MAX : len_field[7:4];
  assign rx_byte_count = legacy_protocol_sel ? legacy_len :
                         (len_field[3:0] > `LEN_MAX) ? `LEN_MAX : len_field[3:0];
endmodule
`default_nettype wire

/* logic/lin_uart_status_config_regs.v */
// Overview of operation
// - Identifier status reads 000 normally, 100..111 for identifiers 60..63.
// - Busy bit 4 is high while receiving or transmitting.
// - Error summary bit 3 is OR of all error flags; raises error interrupt.
// - Writing one to error summary clears it and every error flag.
// - In UART mode a data read clears error summary and receive flag.
// - Header flag set on identifier received or header sent.
// - Transmit flag set on response sent; UART data write clears it.
// - Receive flag set on response received; requests receive interrupt.
// - Low four status flags are write-one-to-clear; upper four read-only.
// - Enable register holds error, header, transmit, receive enables at bits 3..0.
// - Error register holds abort, timeout, overrun, framing, sync, parity, checksum, bit.
// - Bit timing bit 7 set disables resynchronisation.
// - Six-bit samples per bit resets to 32, limited to 8..63.
// - Twelve-bit divider; sample period is divider plus one clocks.
// - Transmit byte count from length upper nibble, clamped to 8.
// - Receive byte count from length lower nibble, clamped to 8.
// - Legacy mode identifier bits 5:4 give length 2, 2, 4, 8.
// - New mode uses six-bit identifier; legacy uses four bits.
// - UART mode ignores length and identifier fields.
// - Protocol select bit clear means new protocol, set means legacy.
// - Any error flag stops activity and returns to abort command.
`timescale 1ns/1ps
`default_nettype none
`include "lin_regs.vh"
module lin_uart_status_config_regs #(
  parameter DIV_W = 12
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Frame engine status and events (events are one-cycle pulses, same clock)
  input wire transfer_active,
  input wire header_done_evt,
  input wire tx_done_evt,
  input wire rx_done_evt,
  input wire [7:0] error_evt,
  input wire uart_mode,
  input wire [7:0] rx_byte,
  // Configuration toward the frame engine
  output reg abort_req_q,
  output reg resync_disable_q,
  output reg [5:0] samples_per_bit_q,
  output reg sample_tick_q,
  output reg [3:0] tx_byte_count_q,
  output reg [3:0] rx_byte_count_q,
  output reg [5:0] frame_id_q,
  output reg [7:0] tx_byte_q,
  output reg tx_byte_load_q,
  // Interrupt requests
  output reg err_irq_q,
  output reg comm_irq_q
);
  // Register state
  reg [3:0] flags_q;
  reg [3:0] irq_en_q;
  reg [7:0] error_flags_q;
  reg [DIV_W-1:0] div_q;
  reg [7:0] resp_len_q;
  reg [5:0] id_q;
  reg legacy_q;
  reg busy_q;
  reg [7:0] rx_data_q;
  reg [2:0] special_q;
  // Parity reads zero until software writes an identifier
  reg id_set_q;
  // Write channel holding
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg wstrb0_q;

  wire [1:0] id_parity_bits;
  wire [5:0] frame_id;
  wire [2:0] special_id;
  wire [3:0] tx_cnt;
  wire [3:0] rx_cnt;
  wire tick;
  wire [7:0] status_rd;
  wire do_write;
  wire do_read;
  wire [7:0] ar_idx;
  wire wr_status;
  wire err_clear;
  wire data_read;
  wire data_write;
  wire [7:0] error_next;
  reg [31:0] rd_mux;
  reg rd_ok;
  reg wr_ok;

  // Identifier and length decode
  id_decode u_id (
    .id_field(id_q),
    .legacy_protocol_sel(legacy_q),
    .len_field(resp_len_q),
    .id_parity_bits(id_parity_bits),
    .frame_id(frame_id),
    .special_id(special_id),
    .tx_byte_count(tx_cnt),
    .rx_byte_count(rx_cnt)
  );

  // Sample clock enable
  sample_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .divider(div_q),
    .run(busy_q),
    .tick_q(tick)
  );

  // Status byte assembly
  assign status_rd = {special_q, busy_q, flags_q};

  // Bus decode
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[9:2];
  assign wr_status = do_write && wstrb0_q && (aw_idx_q == `IDX_STATUS);
  // A UART data read clears the summary, and so every error flag with it
  assign err_clear = (wr_status && wdata_q[`ST_ERR]) || data_read;
  assign data_read = do_read && uart_mode && (ar_idx == `IDX_DATA_PORT);
  assign data_write = do_write && wstrb0_q && uart_mode && (aw_idx_q == `IDX_DATA_PORT);
  // New events win over a clear in the same cycle
  assign error_next = (err_clear ? 8'h00 : error_flags_q) | error_evt;

  // Read mux
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (ar_idx)
      `IDX_STATUS: rd_mux[7:0] = status_rd;
      `IDX_IRQ_EN: rd_mux[7:0] = {4'h0, irq_en_q};
      `IDX_ERROR: rd_mux[7:0] = error_flags_q;
      `IDX_BIT_TIMING: rd_mux[7:0] = {resync_disable_q, 1'b0, samples_per_bit_q};
      `IDX_DIV_LOW: rd_mux[7:0] = div_q[7:0];
      `IDX_DIV_HIGH: rd_mux[7:0] = {4'h0, div_q[DIV_W-1:8]};
      `IDX_RESP_LEN: rd_mux[7:0] = resp_len_q;
      `IDX_FRAME_ID: rd_mux[7:0] = {id_parity_bits & {2{id_set_q}}, id_q};
      `IDX_CONTROL: rd_mux[7:0] = {1'b0, legacy_q, 6'h00};
      `IDX_DATA_PORT: rd_mux[7:0] = rx_data_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // Writable address check
  always @*
  begin
    case (aw_idx_q)
      `IDX_STATUS, `IDX_IRQ_EN, `IDX_ERROR, `IDX_BIT_TIMING, `IDX_DIV_LOW,
      `IDX_DIV_HIGH, `IDX_RESP_LEN, `IDX_FRAME_ID, `IDX_CONTROL,
      `IDX_DATA_PORT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write address and data capture, response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_en_q <= 4'h0;
      resync_disable_q <= 1'b0;
      // Bit timing resets to 32 samples per bit
      samples_per_bit_q <= `RST_SPB;
      div_q <= {DIV_W{1'b0}};
      resp_len_q <= `RST_ZERO;
      id_q <= 6'h00;
      id_set_q <= 1'b0;
      legacy_q <= 1'b0;
      tx_byte_q <= `RST_ZERO;
      tx_byte_load_q <= 1'b0;
    end
    else
    begin
      tx_byte_load_q <= data_write;
      if (do_write && wstrb0_q)
      begin
        case (aw_idx_q)
          `IDX_IRQ_EN: irq_en_q <= wdata_q[3:0];
          `IDX_BIT_TIMING:
          begin
            resync_disable_q <= wdata_q[7];
            if (wdata_q[5:0] >= `SPB_MIN)
              samples_per_bit_q <= wdata_q[5:0];
          end
          `IDX_DIV_LOW: div_q[7:0] <= wdata_q[7:0];
          `IDX_DIV_HIGH: div_q[DIV_W-1:8] <= wdata_q[DIV_W-9:0];
          `IDX_RESP_LEN: resp_len_q <= wdata_q[7:0];
          `IDX_FRAME_ID:
          begin
            id_q <= wdata_q[5:0];
            id_set_q <= 1'b1;
          end
          `IDX_CONTROL: legacy_q <= wdata_q[6];
          `IDX_DATA_PORT: tx_byte_q <= wdata_q[7:0];
          default: legacy_q <= legacy_q;
        endcase
      end
    end
  end

  // Flags, errors and derived outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_q <= 4'h0;
      error_flags_q <= `RST_ZERO;
      busy_q <= 1'b0;
      special_q <= 3'h0;
      rx_data_q <= `RST_ZERO;
      abort_req_q <= 1'b0;
      err_irq_q <= 1'b0;
      comm_irq_q <= 1'b0;
      sample_tick_q <= 1'b0;
      tx_byte_count_q <= 4'h0;
      rx_byte_count_q <= 4'h0;
      frame_id_q <= 6'h00;
    end
    else
    begin
      busy_q <= transfer_active;
      sample_tick_q <= tick;
      error_flags_q <= error_next;
      // Error summary follows the error flags
      flags_q[`ST_ERR] <= |error_next;
      flags_q[`ST_HDR] <= header_done_evt || (flags_q[`ST_HDR] &&
                          !(wr_status && wdata_q[`ST_HDR]));
      flags_q[`ST_TX] <= tx_done_evt || (flags_q[`ST_TX] &&
                         !(wr_status && wdata_q[`ST_TX]) && !data_write);
      flags_q[`ST_RX] <= rx_done_evt || (flags_q[`ST_RX] &&
                         !(wr_status && wdata_q[`ST_RX]) && !data_read);
      if (rx_done_evt && uart_mode)
        rx_data_q <= rx_byte;
      if (header_done_evt)
        special_q <= uart_mode ? 3'h0 : special_id;
      abort_req_q <= |error_evt;
      // Interrupt requests
      err_irq_q <= flags_q[`ST_ERR] && irq_en_q[`ST_ERR];
      comm_irq_q <= |(flags_q[2:0] & irq_en_q[2:0]);
      // UART mode ignores identifier and length fields
      tx_byte_count_q <= uart_mode ? 4'h0 : tx_cnt;
      rx_byte_count_q <= uart_mode ? 4'h0 : rx_cnt;
      frame_id_q <= uart_mode ? 6'h00 : frame_id;
    end
  end
endmodule
`default_nettype wire

/* tb/lin_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lin_regs_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Engine side
  input wire logic transfer_active,
  input wire logic [7:0] error_evt,
  input wire logic uart_mode,
  // Outputs watched
  input wire logic abort_req_q,
  input wire logic sample_tick_q,
  input wire logic [5:0] samples_per_bit_q,
  input wire logic [3:0] tx_byte_count_q,
  input wire logic [3:0] rx_byte_count_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_abort_follows: assert property (|error_evt |=> abort_req_q)
    else $error("abort request missing");
  chk_abort_cause: assert property (abort_req_q |-> $past(|error_evt))
    else $error("abort request without error");
  chk_spb_range: assert property (samples_per_bit_q >= 6'h08)
    else $error("samples per bit below eight");
  chk_tx_count_max: assert property (tx_byte_count_q <= 4'h8)
    else $error("tx byte count above eight");
  chk_rx_count_max: assert property (rx_byte_count_q <= 4'h8)
    else $error("rx byte count above eight");
  chk_uart_counts: assert property (uart_mode [*2] |-> !(|{tx_byte_count_q, rx_byte_count_q}))
    else $error("byte counts used in uart mode");
  chk_tick_idle: assert property (!transfer_active [*4] |-> !sample_tick_q)
    else $error("sample tick while idle");
  chk_tick_busy: assert property (sample_tick_q |-> $past(transfer_active, 3))
    else $error("sample tick without busy");
endmodule
bind lin_uart_status_config_regs lin_regs_sva chk_i (.aclk, .aresetn, .transfer_active,
  .error_evt, .uart_mode, .abort_req_q, .sample_tick_q, .samples_per_bit_q,
  .tx_byte_count_q, .rx_byte_count_q);
`default_nettype wire

/* tb/frame_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module frame_engine_model (
  // Clock
  input wire logic aclk,
  // Engine status and events
  output logic transfer_active,
  output logic header_done_evt,
  output logic tx_done_evt,
  output logic rx_done_evt,
  output logic [7:0] error_evt,
  output logic uart_mode,
  output logic [7:0] rx_byte
);
  // Idle engine at time zero
  initial
  begin
    {transfer_active, header_done_evt, tx_done_evt, rx_done_evt} = 4'h0;
    error_evt = 8'h00;
    uart_mode = 1'b0;
    rx_byte = 8'hFF;
  end
  // One frame: busy, then one-cycle completion pulses
  task automatic run_frame(input logic [2:0] ev, input logic [7:0] err, input logic [7:0] b);
    @(posedge aclk);
    transfer_active <= 1'b1;
    rx_byte <= b;
    repeat (3) @(posedge aclk);
    {header_done_evt, tx_done_evt, rx_done_evt} <= ev;
    error_evt <= err;
    transfer_active <= 1'b0;
    @(posedge aclk);
    {header_done_evt, tx_done_evt, rx_done_evt} <= 3'h0;
    error_evt <= 8'h00;
    rx_byte <= ~b; // Stale byte no longer valid
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lin_regs.vh"
module tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic transfer_active, header_done_evt, tx_done_evt, rx_done_evt, uart_mode;
  logic [7:0] error_evt, rx_byte, tx_byte_q;
  logic abort_req_q, resync_disable_q, sample_tick_q, tx_byte_load_q, err_irq_q, comm_irq_q;
  logic [5:0] samples_per_bit_q, frame_id_q;
  logic [3:0] tx_byte_count_q, rx_byte_count_q;
  int n_fail = 0, checks = 0, cyc = 0, loads = 0, k;
  localparam logic [31:0] M = 32'hFFFFFFFF;
  lin_uart_status_config_regs uut (.*);
  frame_engine_model fe (.*);
  always #4 aclk = ~aclk;
  // Bus write of one register byte
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Bus read of one register
  task automatic rd(input logic [7:0] i);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, i, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
    rd(i);
    chk(d & m, e);
  endtask
  // Identifier with its two parity bits on top
  function automatic logic [7:0] pid(input logic [5:0] id);
    pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction
  task automatic finish_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (tx_byte_load_q === 1'b1) loads++;
    if (cyc == 5000)
    begin
      n_fail++;
      finish_test;
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 8'hC1; k <= 8'hC8; k++) rc(k[7:0], M, (k == 8'hC4) ? 32'h20 : 32'h0);
    rd(8'hE0);
    chk(d, 32'h0);
    chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
    $display("reset and unmapped test done");
    wr(8'hC2, 8'h0F);
    rc(8'hC2, M, 32'h0F);
    wr(8'hC5, 8'hA5);
    wr(8'hC6, 8'h0C);
    rc(8'hC5, M, 32'hA5);
    rc(8'hC6, M, 32'h0C);
    wr(8'hC5, 8'h03);
    wr(8'hC6, 8'h00);
    fe.transfer_active <= 1'b1;
    rc(8'hC1, 32'h10, 32'h10);
    for (k = 0; k < 50 && !sample_tick_q; k++) @(posedge aclk);
    @(posedge aclk);
    for (k = 1; k < 50 && !sample_tick_q; k++) @(posedge aclk);
    chk(k, 4);
    fe.transfer_active <= 1'b0;
    rc(8'hC1, 32'h10, 32'h0);
    wr(8'hC4, 8'hC8);
    rc(8'hC4, M, 32'h88);
    chk({resync_disable_q, samples_per_bit_q}, 7'h48);
    wr(8'hC4, 8'h84);
    rc(8'hC4, 32'h3F, 32'h08);
    wr(8'hC7, 8'h9A);
    rc(8'hC7, M, 32'h9A);
    chk({tx_byte_count_q, rx_byte_count_q}, 8'h88);
    wr(8'hC7, 8'h35);
    repeat (3) @(posedge aclk);
    chk({tx_byte_count_q, rx_byte_count_q}, 8'h35);
    $display("config test done");
    wr(8'hC0, 8'h40);
    for (k = 0; k < 4; k++)
    begin
      wr(8'hC8, {2'h0, k[1:0], 4'h9});
      repeat (3) @(posedge aclk);
      chk({frame_id_q, rx_byte_count_q}, {6'h09, (k < 2) ? 4'h2 : (k == 2) ? 4'h4 : 4'h8});
    end
    wr(8'hC0, 8'h00);
    wr(8'hC8, 8'h2B);
    rc(8'hC8, M, {24'h0, pid(6'h2B)});
    chk(frame_id_q, 6'h2B);
    fe.run_frame(3'h4, 8'h00, 8'h00);
    rc(8'hC1, 32'h9F, 32'h04);
    chk(comm_irq_q, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      wr(8'hC1, 8'h04);
      wr(8'hC8, 8'h3C + k[7:0]);
      fe.run_frame(3'h4, 8'h00, 8'h00);
      rc(8'hC1, 32'hEF, {24'h0, 1'b1, k[1:0], 5'h04});
    end
    wr(8'hC1, 8'h04);
    $display("identifier test done");
    fe.run_frame(3'h3, 8'h00, 8'h00);
    wr(8'hC1, 8'h00);
    rc(8'hC1, 32'h0F, 32'h03);
    wr(8'hC2, 8'h08);
    wr(8'hC1, 8'h02);
    rc(8'hC1, 32'h0F, 32'h01);
    chk(comm_irq_q, 1'b0);
    for (k = 0; k < 8; k++)
    begin
      fe.run_frame(3'h0, 8'h01 << k, 8'h00);
      rc(8'hC3, M, 32'h1 << k);
      rc(8'hC1, 32'h0F, 32'h09);
      chk(err_irq_q, 1'b1);
      wr(8'hC1, 8'h08);
    end
    rc(8'hC3, M, 32'h0);
    $display("flag and error test done");
    fe.uart_mode <= 1'b1;
    fe.run_frame(3'h1, 8'h10, 8'h5A);
    rc(8'hCA, M, 32'h5A);
    rc(8'hC1, 32'h09, 32'h0);
    fe.run_frame(3'h2, 8'h00, 8'h00);
    wr(8'hCA, 8'h33);
    rc(8'hC1, 32'h02, 32'h0);
    chk({tx_byte_q, rx_byte_count_q}, 12'h330);
    chk(loads, 1); // One load pulse per UART data write
    $display("uart test done");
    finish_test;
  end
endmodule
`default_nettype wire
